// ==== verilog/bcpc_pkg.sv ====
// shared constants for the bus, clock and pin control block
package bcpc_pkg;
  localparam int BCFG_EXT0 = 0;
  localparam int BCFG_TRACE = 3;
  localparam int BCFG_EXT7 = 7;
  localparam logic [7:0] BCFG_RESET = 8'h00;
  localparam logic [7:0] BCFG_EMUL = 8'h89;
  localparam int TCR_SRC_BIT = 1;
  localparam int TCR_FOSC_BIT = 2;
  localparam logic [7:0] TCR_RESET = 8'h00;
  localparam logic [7:0] PCS_RESET = 8'h00;
  localparam logic [7:0] PORT3_RESET = 8'hFF;
  localparam int SETTLE_MS = 100;
  localparam int CLK_MHZ = 250;
  typedef enum logic [1:0] {
    BCPC_RUNNING = 2'b00,
    BCPC_WAITING = 2'b01,
    BCPC_STOPPED = 2'b10
  } bcpc_run_t;
endpackage

// ==== verilog/bcpc_if.sv ====
// pin-level carrier between the device end and the bus master end
`timescale 1ns/1ns
`default_nettype none
interface bcpc_if;
  logic [15:0] addrDev;
  logic addrDevOe;
  logic [15:0] addrMst;
  logic addrMstOe;
  logic [7:0] dataDev;
  logic dataDevOe;
  logic [7:0] dataMst;
  logic dataMstOe;
  logic writeStrobeDevN;
  logic writeStrobeDevOe;
  logic writeStrobeMstN;
  logic writeStrobeMstOe;
  logic busTakeoverEnable;
  logic runOut;
  logic phaseTwoClock;
  logic port3Out;
  logic slowOscOutN;
  logic fastOscOutN;
  logic [15:0] addrBus;
  logic [7:0] dataBus;
  logic writeStrobeN;
  assign addrBus = addrDevOe ? addrDev : (addrMstOe ? addrMst : 16'hFFFF);
  assign dataBus = dataDevOe ? dataDev : (dataMstOe ? dataMst : 8'hFF);
  assign writeStrobeN = writeStrobeDevOe ? writeStrobeDevN : (writeStrobeMstOe ? writeStrobeMstN : 1'b1);
  modport device (
    output addrDev, addrDevOe, dataDev, dataDevOe, writeStrobeDevN, writeStrobeDevOe,
    output runOut, phaseTwoClock, port3Out, slowOscOutN, fastOscOutN,
    input busTakeoverEnable, addrBus, dataBus, writeStrobeN
  );
  modport master (
    output addrMst, addrMstOe, dataMst, dataMstOe, writeStrobeMstN, writeStrobeMstOe,
    output busTakeoverEnable,
    input runOut, phaseTwoClock, port3Out, addrBus, dataBus, writeStrobeN
  );
endinterface
`default_nettype wire

// ==== verilog/bcpc_clock_select.sv ====
// phase-two source selection, fast oscillator gating and oscillator outputs
`timescale 1ns/1ns
`default_nettype none
module bcpc_clock_select
  import bcpc_pkg::*;
(
  input wire logic clk,
  input wire logic reset_n,
  input wire logic slowClockIn,
  input wire logic fastClockIn,
  input wire logic fastOscEnable,
  input wire logic clockSourceSelect,
  input wire logic clockStopped,
  output logic phaseTwo,
  output logic slowOscOutN,
  output logic fastOscOutN
);
  logic fastGated;
  assign fastGated = fastClockIn & fastOscEnable;
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      slowOscOutN <= 1'b1;
      fastOscOutN <= 1'b1;
    end else begin
      slowOscOutN <= ~slowClockIn;
      fastOscOutN <= ~fastGated;
    end
  end
  // stopped clock parks high, the preferred resting level
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      phaseTwo <= 1'b1;
    end else if (clockStopped) begin
      phaseTwo <= 1'b1;
    end else begin
      phaseTwo <= clockSourceSelect ? fastGated : slowClockIn;
    end
  end
endmodule
`default_nettype wire

// ==== verilog/bcpc_device.sv ====
// device end: pin muxing, write strobe, run output, clock control and bus takeover
`timescale 1ns/1ns
`default_nettype none
module bcpc_device
  import bcpc_pkg::*;
(
  input wire logic clk,
  input wire logic reset_n,
  bcpc_if.device pins,
  input wire logic slowClockIn,
  input wire logic fastClockIn,
  input wire logic [7:0] busConfigWrData,
  input wire logic busConfigWrEn,
  input wire logic [7:0] timerControlWrData,
  input wire logic timerControlWrEn,
  input wire logic [7:0] chipSelectWrData,
  input wire logic chipSelectWrEn,
  input wire logic [7:0] port3WrData,
  input wire logic port3WrEn,
  input wire logic [15:0] coreAddr,
  input wire logic [7:0] coreWrData,
  input wire logic coreWrite,
  input wire logic coreAccess,
  input wire logic coreExternal,
  input wire logic coreOpcodeFetch,
  input wire logic waitInstruction,
  input wire logic stopInstruction,
  input wire logic interruptRequest,
  input wire logic chipSelectSevenN,
  input wire logic [7:0] dmaRdData,
  output logic [7:0] busConfigReg,
  output logic [7:0] timerControlReg,
  output logic coreHalted,
  output logic dmaWrite,
  output logic [15:0] dmaAddr,
  output logic [7:0] dmaWrData,
  output logic dmaActive,
  output logic [15:0] portAddrOut,
  output logic [7:0] port2Out
);
  bcpc_run_t runState_r;
  logic [7:0] chipSelectReg_r;
  logic [7:0] port3Data_r;
  logic resetSeen_r;
  logic takeover_r;
  logic takeoverPrev_r;
  logic fallPhaseLow_r;
  logic strobePrevN_r;
  logic phaseTwo;
  logic phaseLow;
  logic busMode;
  logic traceMode;
  logic runLevel;

  function automatic logic busSelected(input logic [7:0] cfg);
    busSelected = cfg[BCFG_EXT0] | cfg[BCFG_TRACE] | cfg[BCFG_EXT7];
  endfunction

  assign busMode = busSelected(busConfigReg);
  assign traceMode = busConfigReg[BCFG_TRACE];
  assign phaseLow = ~phaseTwo;
  assign runLevel = (runState_r == BCPC_RUNNING);

  ////////////////////////////////////////////////////////////////
  // configuration registers; the strap is caught on the first clocked edge after release
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      busConfigReg <= BCFG_RESET;
      resetSeen_r <= 1'b0;
    end else if (!resetSeen_r) begin
      resetSeen_r <= 1'b1;
      busConfigReg <= pins.busTakeoverEnable ? BCFG_RESET : BCFG_EMUL;
    end else if (busConfigWrEn) begin
      busConfigReg <= busConfigWrData;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      timerControlReg <= TCR_RESET;
    end else if (timerControlWrEn) begin
      timerControlReg <= timerControlWrData;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      chipSelectReg_r <= PCS_RESET;
      port3Data_r <= PORT3_RESET;
    end else begin
      if (chipSelectWrEn) begin
        chipSelectReg_r <= chipSelectWrData;
      end
      if (port3WrEn) begin
        port3Data_r <= port3WrData;
      end
    end
  end

  ////////////////////////////////////////////////////////////////
  // clocking
  bcpc_clock_select clockSel (
    .clk(clk),
    .reset_n(reset_n),
    .slowClockIn(slowClockIn),
    .fastClockIn(fastClockIn),
    .fastOscEnable(timerControlReg[TCR_FOSC_BIT]),
    .clockSourceSelect(timerControlReg[TCR_SRC_BIT]),
    .clockStopped(runState_r == BCPC_STOPPED),
    .phaseTwo(phaseTwo),
    .slowOscOutN(pins.slowOscOutN),
    .fastOscOutN(pins.fastOscOutN)
  );
  assign pins.phaseTwoClock = phaseTwo;

  ////////////////////////////////////////////////////////////////
  // run state; instructions are taken only during phase-two high
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      runState_r <= BCPC_RUNNING;
    end else begin
      case (runState_r)
        BCPC_RUNNING: begin
          if (phaseTwo && stopInstruction) begin
            runState_r <= BCPC_STOPPED;
          end else if (phaseTwo && waitInstruction) begin
            runState_r <= BCPC_WAITING;
          end
        end
        BCPC_WAITING: begin
          if (interruptRequest) begin
            runState_r <= BCPC_RUNNING;
          end
        end
        BCPC_STOPPED: begin
          if (interruptRequest) begin
            runState_r <= BCPC_RUNNING;
          end
        end
        default: begin
          runState_r <= BCPC_RUNNING;
        end
      endcase
    end
  end

  // run pin ignores the takeover input apart from the reset strap, which can select trace mode
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      pins.runOut <= 1'b1;
    end else if (traceMode && phaseLow) begin
      pins.runOut <= coreOpcodeFetch;
    end else begin
      pins.runOut <= runLevel;
    end
  end

  ////////////////////////////////////////////////////////////////
  // bus takeover: direction changes only when the fall lands in phase low;
  // the phase is the one seen at the last edge with the enable still high, as the master sees it
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      takeoverPrev_r <= 1'b1;
      fallPhaseLow_r <= 1'b0;
    end else begin
      takeoverPrev_r <= pins.busTakeoverEnable;
      fallPhaseLow_r <= phaseLow;
    end
  end

  // a fall in phase high only halts the core, even if the enable stays low into phase low
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      takeover_r <= 1'b0;
    end else if (pins.busTakeoverEnable) begin
      takeover_r <= 1'b0;
    end else if (takeoverPrev_r && fallPhaseLow_r) begin
      takeover_r <= 1'b1;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      coreHalted <= 1'b0;
      dmaActive <= 1'b0;
    end else begin
      coreHalted <= !runLevel || !pins.busTakeoverEnable;
      dmaActive <= takeover_r;
    end
  end

  // dma access to on-chip space, strobe sampled from the pin
  // the write lands on the second low sample; on the first the data pins may still carry our own read data
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      dmaWrite <= 1'b0;
      dmaAddr <= 16'h0000;
      dmaWrData <= 8'h00;
      strobePrevN_r <= 1'b1;
    end else begin
      strobePrevN_r <= pins.writeStrobeN;
      dmaWrite <= takeover_r && !pins.writeStrobeN && !strobePrevN_r;
      dmaAddr <= pins.addrBus;
      dmaWrData <= pins.dataBus;
    end
  end

  ////////////////////////////////////////////////////////////////
  // pin drivers
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      pins.addrDev <= 16'h0000;
      pins.addrDevOe <= 1'b0;
      pins.dataDev <= 8'h00;
      pins.dataDevOe <= 1'b0;
      pins.writeStrobeDevN <= 1'b1;
      pins.writeStrobeDevOe <= 1'b0;
    end else if (takeover_r) begin
      pins.addrDevOe <= 1'b0;
      pins.writeStrobeDevOe <= 1'b0;
      pins.dataDev <= dmaRdData;
      pins.dataDevOe <= pins.writeStrobeN;
    end else begin
      pins.addrDev <= (coreExternal || traceMode) ? coreAddr : 16'hFFFF;
      pins.addrDevOe <= busMode;
      pins.writeStrobeDevN <= !(coreAccess && coreWrite && coreExternal && phaseTwo);
      // the strobe pin is dedicated, not a port bit, so it is driven in every mode
      pins.writeStrobeDevOe <= 1'b1;
      // external cycles float the data pins in phase low
      if (coreExternal) begin
        pins.dataDev <= coreWrData;
        pins.dataDevOe <= busMode && coreAccess && coreWrite && phaseTwo;
      end else if (traceMode) begin
        pins.dataDev <= coreWrite ? coreWrData : dmaRdData;
        pins.dataDevOe <= coreAccess;
      end else begin
        pins.dataDev <= 8'hFF;
        pins.dataDevOe <= busMode;
      end
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      pins.port3Out <= 1'b1;
      portAddrOut <= 16'h0000;
      port2Out <= 8'h00;
    end else begin
      if (chipSelectReg_r[7] || busConfigReg[BCFG_EXT7]) begin
        pins.port3Out <= chipSelectSevenN;
      end else begin
        pins.port3Out <= port3Data_r[7];
      end
      portAddrOut <= busMode ? 16'h0000 : coreAddr;
      port2Out <= busMode ? 8'h00 : coreWrData;
    end
  end
endmodule
`default_nettype wire

// ==== verilog/bcpc_master.sv ====
// far end: external emulator or dma master that can take the bus
`timescale 1ns/1ns
`default_nettype none
module bcpc_master
  import bcpc_pkg::*;
(
  input wire logic clk,
  input wire logic reset_n,
  bcpc_if.master pins,
  input wire logic takeReq,
  input wire logic accWrite,
  input wire logic accStart,
  input wire logic [15:0] accAddr,
  input wire logic [7:0] accWrData,
  output logic [7:0] accRdData,
  output logic accDone,
  output logic runSeen
);
  typedef enum logic [1:0] {
    BCPC_ACC_IDLE = 2'b00,
    BCPC_ACC_DATA = 2'b01,
    BCPC_ACC_DONE = 2'b10
  } bcpc_acc_t;
  bcpc_acc_t step_r;
  logic ownBus_r;
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      pins.busTakeoverEnable <= 1'b1;
    end else if (takeReq) begin
      if (!pins.phaseTwoClock) begin
        pins.busTakeoverEnable <= 1'b0;
      end
    end else begin
      pins.busTakeoverEnable <= 1'b1;
    end
  end

  // enables wait the same two edges the device needs to let go, so the pins never see two drivers
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      ownBus_r <= 1'b0;
      pins.addrMstOe <= 1'b0;
      pins.writeStrobeMstOe <= 1'b0;
    end else begin
      ownBus_r <= !pins.busTakeoverEnable;
      pins.addrMstOe <= ownBus_r && !pins.busTakeoverEnable;
      pins.writeStrobeMstOe <= ownBus_r && !pins.busTakeoverEnable;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      pins.addrMst <= 16'h0000;
      pins.dataMst <= 8'h00;
      pins.dataMstOe <= 1'b0;
      pins.writeStrobeMstN <= 1'b1;
      step_r <= BCPC_ACC_IDLE;
      accDone <= 1'b0;
      accRdData <= 8'h00;
    end else begin
      accDone <= 1'b0;
      case (step_r)
        BCPC_ACC_IDLE: begin
          if (accStart && !pins.busTakeoverEnable) begin
            pins.addrMst <= accAddr;
            pins.dataMst <= accWrData;
            pins.writeStrobeMstN <= !accWrite;
            step_r <= BCPC_ACC_DATA;
          end
        end
        BCPC_ACC_DATA: begin
          // data follows the strobe by one edge, once the device has seen it low and stopped driving
          pins.dataMstOe <= !pins.writeStrobeMstN;
          step_r <= BCPC_ACC_DONE;
        end
        default: begin
          accDone <= 1'b1;
          accRdData <= pins.dataBus;
          pins.writeStrobeMstN <= 1'b1;
          pins.dataMstOe <= 1'b0;
          step_r <= BCPC_ACC_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      runSeen <= 1'b1;
    end else if (pins.phaseTwoClock) begin
      runSeen <= pins.runOut;
    end
  end
endmodule
`default_nettype wire

// ==== verification/bcpc_assertions.sv ====
// pin-level checks on the carrier joining the device and master ends
`timescale 1ns/1ns
`default_nettype none
module bcpc_assertions (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic addrDevOe,
  input wire logic addrMstOe,
  input wire logic dataDevOe,
  input wire logic dataMstOe,
  input wire logic writeStrobeDevOe,
  input wire logic writeStrobeMstOe,
  input wire logic writeStrobeMstN,
  input wire logic busTakeoverEnable,
  input wire logic runOut,
  input wire logic phaseTwoClock
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  ////////////////////////////////////////////////////////////////////////
  addr_one_owner_a: assert property (!(addrDevOe && addrMstOe))
    else $error("address pins driven by both ends");
  data_one_owner_a: assert property (!(dataDevOe && dataMstOe))
    else $error("data pins driven by both ends");
  strobe_one_owner_a: assert property (!(writeStrobeDevOe && writeStrobeMstOe))
    else $error("write strobe driven by both ends");
  master_write_takeover_a: assert property (writeStrobeMstOe && !writeStrobeMstN |-> !busTakeoverEnable)
    else $error("master write strobe outside takeover");
  reset_run_high_a: assert property ($rose(reset_n) |-> runOut)
    else $error("run low right after reset");
  // takeover needs the enable low across a phase-low edge, then one more edge for the enables
  takeover_phase_low_a: assert property ($fell(busTakeoverEnable) && !$past(phaseTwoClock) ##1 !busTakeoverEnable
    |=> !addrDevOe && !writeStrobeDevOe)
    else $error("device kept bus after takeover");
  single_step_hold_a: assert property ($fell(busTakeoverEnable) && $past(phaseTwoClock)
    |=> $stable(addrDevOe) && $stable(writeStrobeDevOe))
    else $error("pin direction moved on phase-high takeover");
  core_owns_strobe_a: assert property (busTakeoverEnable [*4] |-> writeStrobeDevOe)
    else $error("device not driving strobe");
  takeover_run_free_a: assert property ($changed(busTakeoverEnable) && runOut |=> runOut)
    else $error("run moved with takeover enable");
endmodule
`default_nettype wire

// ==== verification/test_bus_clock_pin_control.sv ====
// self-checking bench joining the device and master ends
`timescale 1ns/1ns
`default_nettype none
module test_bus_clock_pin_control;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic slowClockIn = 1'b0, fastClockIn = 1'b0, oscFree = 1'b1;
  logic [3:0] div = 4'h0, en = 4'h0;
  logic [7:0] wd = 8'h00, dmaRd = 8'h00, accWrData = 8'h00;
  logic coreWrite = 1'b0, coreAccess = 1'b0, coreExternal = 1'b0, waitI = 1'b0, stopI = 1'b0, irq = 1'b0;
  logic takeReq = 1'b0, accWrite = 1'b0, accStart = 1'b0;
  logic [15:0] accAddr = 16'h0000, dmaAddr;
  logic [7:0] busConfigReg, timerControlReg, dmaWrData, accRdData;
  logic coreHalted, dmaWrite, dmaActive, accDone;
  logic fetch = 1'b0, runSeen;
  logic [15:0] portAddr;
  logic [7:0] port2;
  int fail_count = 0;
  int tests_run = 0;
  bcpc_if u_bcpc_if ();
  wire p2 = u_bcpc_if.phaseTwoClock;
  wire runOut = u_bcpc_if.runOut;
  always #2 clk = ~clk;
  // slow period 16, fast period 4: exactly the quarter ratio
  always @(posedge clk) begin
    div <= div + 4'h1;
    if (oscFree) begin
      slowClockIn <= div[3];
      fastClockIn <= div[1];
    end
  end
  bcpc_device u_bcpc_device (.clk(clk), .reset_n(reset_n), .pins(u_bcpc_if), .slowClockIn(slowClockIn),
    .fastClockIn(fastClockIn), .busConfigWrData(wd), .busConfigWrEn(en[0]), .timerControlWrData(wd),
    .timerControlWrEn(en[1]), .chipSelectWrData(wd), .chipSelectWrEn(en[2]), .port3WrData(wd),
    .port3WrEn(en[3]), .coreAddr(16'h1234), .coreWrData(8'h5A), .coreWrite(coreWrite),
    .coreAccess(coreAccess), .coreExternal(coreExternal), .coreOpcodeFetch(fetch), .waitInstruction(waitI),
    .stopInstruction(stopI), .interruptRequest(irq), .chipSelectSevenN(1'b1), .dmaRdData(dmaRd),
    .busConfigReg(busConfigReg), .timerControlReg(timerControlReg), .coreHalted(coreHalted),
    .dmaWrite(dmaWrite), .dmaAddr(dmaAddr), .dmaWrData(dmaWrData), .dmaActive(dmaActive),
    .portAddrOut(portAddr), .port2Out(port2));
  bcpc_master u_bcpc_master (.clk(clk), .reset_n(reset_n), .pins(u_bcpc_if), .takeReq(takeReq),
    .accWrite(accWrite), .accStart(accStart), .accAddr(accAddr), .accWrData(accWrData),
    .accRdData(accRdData), .accDone(accDone), .runSeen(runSeen));
  bcpc_assertions u_bcpc_assertions (.clk(clk), .reset_n(reset_n), .addrDevOe(u_bcpc_if.addrDevOe),
    .addrMstOe(u_bcpc_if.addrMstOe), .dataDevOe(u_bcpc_if.dataDevOe), .dataMstOe(u_bcpc_if.dataMstOe),
    .writeStrobeDevOe(u_bcpc_if.writeStrobeDevOe), .writeStrobeMstOe(u_bcpc_if.writeStrobeMstOe),
    .writeStrobeMstN(u_bcpc_if.writeStrobeMstN), .busTakeoverEnable(u_bcpc_if.busTakeoverEnable),
    .runOut(runOut), .phaseTwoClock(p2));
  ////////////////////////////////////////////////////////////////////////
  task chk(input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      fail_count++;
      $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task report_and_stop;
    $display("checks %0d, mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task limit(input int n, input int lim);
    if (n >= lim) begin
      fail_count++;
      report_and_stop;
    end
  endtask
  task wreg(input int k, input logic [7:0] d);
    @(posedge clk);
    wd <= d;
    en <= 4'h1 << k;
    @(posedge clk);
    en <= 4'h0;
    repeat (3) @(posedge clk);
  endtask
  ////////////////////////////////////////////////////////////////////////
  task t_regs;
    int bits [3] = '{0, 3, 7};
    chk(busConfigReg, 8'h00);
    chk(timerControlReg, 8'h00);
    coreAccess <= 1'b1;
    coreExternal <= 1'b1;
    wreg(0, 8'h00);
    chk(u_bcpc_if.addrDevOe, 1'b0);
    chk(portAddr, 16'h1234);
    chk(port2, 8'h5A);
    foreach (bits[i]) begin
      wreg(0, 8'h01 << bits[i]);
      chk(u_bcpc_if.addrDevOe, 1'b1);
      chk(portAddr, 16'h0000);
      chk(u_bcpc_if.addrBus, 16'h1234);
    end
    coreAccess <= 1'b0;
    wreg(0, 8'h00);
  endtask
  task t_cs7;
    wreg(3, 8'h7F);
    chk(u_bcpc_if.port3Out, 1'b0);
    wreg(2, 8'h80);
    chk(u_bcpc_if.port3Out, 1'b1);
    wreg(2, 8'h00);
    wreg(0, 8'h80);
    chk(u_bcpc_if.port3Out, 1'b1);
    wreg(0, 8'h00);
  endtask
  task t_clk;
    int lv, n;
    logic last;
    oscFree <= 1'b0;
    wreg(1, 8'h04);
    for (lv = 0; lv < 2; lv++) begin
      slowClockIn <= lv[0];
      fastClockIn <= lv[0];
      repeat (3) @(posedge clk);
      chk(u_bcpc_if.slowOscOutN, !lv[0]);
      chk(u_bcpc_if.fastOscOutN, !lv[0]);
    end
    oscFree <= 1'b1;
    // settling wait shortened to a few cycles; the real figure is far beyond any run length
    repeat (8) @(posedge clk);
    for (lv = 0; lv < 2; lv++) begin
      wreg(1, lv ? 8'h06 : 8'h04);
      n = 0;
      last = p2;
      repeat (64) begin
        @(posedge clk);
        n += (p2 === 1'b1 && last === 1'b0);
        last = p2;
      end
      chk(n > 8, lv[0]);
    end
    wreg(1, 8'h00);
    n = 0;
    last = u_bcpc_if.fastOscOutN;
    repeat (16) begin
      @(posedge clk);
      n += (u_bcpc_if.fastOscOutN !== last);
      last = u_bcpc_if.fastOscOutN;
    end
    chk(n == 0, 1'b1);
  endtask
  task t_run;
    int k, n;
    for (k = 0; k < 2; k++) begin
      n = 0;
      while (n < 40 && p2 !== 1'b0) begin
        @(posedge clk);
        n++;
      end
      while (n < 80 && p2 !== 1'b1) begin
        @(posedge clk);
        n++;
      end
      limit(n, 80);
      waitI <= (k == 0);
      stopI <= (k == 1);
      @(posedge clk);
      waitI <= 1'b0;
      stopI <= 1'b0;
      repeat (4) @(posedge clk);
      chk(runOut, 1'b0);
      chk(coreHalted, 1'b1);
      n = 0;
      repeat (24) begin
        @(posedge clk);
        n += (p2 === 1'b0);
      end
      chk(n == 0, k[0]);
      chk(runSeen, 1'b0);
      chk(runOut, 1'b0);
      irq <= 1'b1;
      n = 0;
      while (n < 20 && runOut !== 1'b1) begin
        @(posedge clk);
        n++;
      end
      limit(n, 20);
      irq <= 1'b0;
      chk(runOut, 1'b1);
    end
  endtask
  task acc(input logic w, input logic [15:0] a, input logic [7:0] d);
    logic gotW, gotD;
    gotW = 1'b0;
    gotD = 1'b0;
    dmaRd <= 8'h3C;
    accWrite <= w;
    accAddr <= a;
    accWrData <= d;
    accStart <= 1'b1;
    @(posedge clk);
    accStart <= 1'b0;
    repeat (12) begin
      @(posedge clk);
      if (dmaWrite === 1'b1) begin
        gotW = 1'b1;
        chk(dmaAddr, a);
        chk(dmaWrData, d);
      end
      if (accDone === 1'b1) begin
        gotD = 1'b1;
        if (!w) chk(accRdData, 8'h3C);
      end
    end
    chk(gotW, w);
    chk(gotD, 1'b1);
  endtask
  task t_dma;
    takeReq <= 1'b1;
    repeat (24) @(posedge clk);
    chk(dmaActive, 1'b1);
    chk(runOut, 1'b1);
    acc(1'b1, 16'h0040, 8'hA5);
    acc(1'b0, 16'h0041, 8'h00);
    takeReq <= 1'b0;
    repeat (24) @(posedge clk);
    chk(u_bcpc_if.writeStrobeDevOe, 1'b1);
  endtask
  task t_strobe;
    int m, n;
    wreg(0, 8'h81);
    coreAccess <= 1'b1;
    for (m = 0; m < 3; m++) begin
      coreExternal <= (m != 0);
      coreWrite <= (m != 1);
      n = 0;
      repeat (32) begin
        @(posedge clk);
        n += (u_bcpc_if.writeStrobeN === 1'b0);
      end
      chk(n > 0, m == 2);
    end
  endtask
  task t_trace;
    int t, n, d;
    coreExternal <= 1'b0;
    for (t = 0; t < 3; t++) begin
      fetch <= (t == 2);
      wreg(0, t ? 8'h89 : 8'h81);
      n = 0;
      d = 0;
      repeat (32) begin
        @(posedge clk);
        n += (runOut === 1'b0);
        d += (u_bcpc_if.dataBus === 8'h5A);
      end
      chk(n > 0, t == 1);
      chk(d > 0, t != 0);
    end
    fetch <= 1'b0;
    coreAccess <= 1'b0;
    wreg(0, 8'h00);
  endtask
  initial begin
    repeat (6) @(posedge clk);
    reset_n <= 1'b1;
    repeat (3) @(posedge clk);
    t_regs;
    t_cs7;
    t_clk;
    t_run;
    t_dma;
    t_strobe;
    t_trace;
    report_and_stop;
  end
endmodule
`default_nettype wire
